/* File: gtcp_defs.vh */
`ifndef GTCP_DEFS_VH
`define GTCP_DEFS_VH
`define GTCP_A_CFG 4'h0
`define GTCP_A_MODE 4'h1
`define GTCP_A_CTL 4'h2
`define GTCP_A_IMR 4'h3
`define GTCP_A_RIS 4'h4
`define GTCP_A_MIS 4'h5
`define GTCP_A_ICR 4'h6
`define GTCP_A_ILR 4'h7
`define GTCP_A_MATCH 4'h8
`define GTCP_A_PR 4'h9
`define GTCP_A_CNT 4'ha
`define GTCP_A_CAP 4'hb
`define GTCP_CTL_EN 0
`define GTCP_CTL_EVT_LO 2
`define GTCP_CTL_PWML 6
`define GTCP_CTL_RTC 4
`define GTCP_MODE_AMS 3
`define GTCP_MODE_CMR 2
`define GTCP_IRQ_TO 0
`define GTCP_IRQ_CM 1
`define GTCP_IRQ_CE 2
`define GTCP_IRQ_RTC 3
`define GTCP_MR_ONESHOT 2'h1
`define GTCP_MR_PERIODIC 2'h2
`define GTCP_MR_CAPTURE 2'h3
`define GTCP_EVT_RISE 2'h0
`define GTCP_EVT_FALL 2'h1
`define GTCP_EVT_BOTH 2'h3
`define GTCP_CFG_16 3'h4
`define GTCP_LOAD_RST 16'hffff
`endif

/* File: gtcp_edge_det.v */
`timescale 1ns/1ns
`include "gtcp_defs.vh"
module gtcp_edge_det (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // pin and selection
   input wire pin_i,
   input wire [1:0] sel_i,
   // event
   output reg evt_o
);
   reg meta_r;
   reg sync_r;
   reg prev_r;
   wire rise;
   wire fall;
   assign rise = sync_r & ~prev_r;
   assign fall = ~sync_r & prev_r;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
         prev_r <= 1'b0;
         evt_o <= 1'b0;
      end else begin
         meta_r <= pin_i;
         sync_r <= meta_r;
         prev_r <= sync_r;
         case (sel_i)
            `GTCP_EVT_RISE: evt_o <= rise;
            `GTCP_EVT_FALL: evt_o <= fall;
            `GTCP_EVT_BOTH: evt_o <= rise | fall;
            default: evt_o <= 1'b0;
         endcase
      end
   end
endmodule // gtcp_edge_det

/* File: gtcp_prescale.v */
`timescale 1ns/1ns
module gtcp_prescale #(
   parameter W = 8
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // control
   input wire run_i,
   input wire bypass_i,
   input wire [W-1:0] div_i,
   // tick
   output wire tick_o
);
   reg [W-1:0] cnt_r;
   assign tick_o = run_i & (bypass_i | (cnt_r == {W{1'b0}}));
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cnt_r <= {W{1'b0}};
      end else if (!run_i || bypass_i) begin
         cnt_r <= div_i;
      end else if (cnt_r == {W{1'b0}}) begin
         cnt_r <= div_i;
      end else begin
         cnt_r <= cnt_r - 1'b1;
      end
   end
endmodule // gtcp_prescale

/* File: gtcp_timer.v */
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ns
`include "gtcp_defs.vh"
module gtcp_timer #(
   parameter W = 16
) (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // register port
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   output reg [31:0] rdata_o,
   // capture compare pin
   input wire ccp_i,
   output reg ccp_o,
   output reg ccp_oe_o
);
   reg [2:0] cfg_r;
   reg [3:0] mode_r;
   reg [6:0] ctl_r;
   reg [3:0] imr_r;
   reg [3:0] ris_r;
   reg [W-1:0] load_r;
   reg [W-1:0] match_r;
   reg [7:0] pr_r;
   reg [W-1:0] cnt_r;
   reg [W-1:0] cap_r;
   reg pwm_r;
   reg [3:0] set_nxt;
   reg [W-1:0] cnt_nxt;
   reg en_clr_nxt;
   wire en;
   wire [1:0] mr;
   wire cmr;
   wire ams;
   wire pwm_mode;
   wire ecnt_mode;
   wire etime_mode;
   wire cap_mode;
   wire evt;
   wire tick;
   wire ctl_wr;
   assign en = ctl_r[`GTCP_CTL_EN];
   assign mr = mode_r[1:0];
   assign cmr = mode_r[`GTCP_MODE_CMR];
   assign ams = mode_r[`GTCP_MODE_AMS];
   assign pwm_mode = ams & ~cmr & (mr == `GTCP_MR_PERIODIC);
   assign ecnt_mode = ~ams & ~cmr & (mr == `GTCP_MR_CAPTURE);
   assign etime_mode = ~ams & cmr & (mr == `GTCP_MR_CAPTURE);
   assign cap_mode = ecnt_mode | etime_mode | pwm_mode;
   assign ctl_wr = wr_i && (addr_i == `GTCP_A_CTL);

   gtcp_edge_det u_edge (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i(ccp_i),
      .sel_i(ctl_r[`GTCP_CTL_EVT_LO+1:`GTCP_CTL_EVT_LO]),
      .evt_o(evt)
   );

   gtcp_prescale #(.W(8)) u_pre (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .run_i(en),
      .bypass_i(cap_mode),
      .div_i(pr_r),
      .tick_o(tick)
   );

   // counter and event logic
   always @* begin
      set_nxt = 4'h0;
      cnt_nxt = cnt_r;
      en_clr_nxt = 1'b0;
      if (en) begin
         if (ecnt_mode) begin
            if (evt) begin
               if (cnt_r - 1'b1 == match_r) begin
                  cnt_nxt = load_r;
                  en_clr_nxt = 1'b1;
                  set_nxt[`GTCP_IRQ_CM] = 1'b1;
               end else begin
                  cnt_nxt = cnt_r - 1'b1;
               end
            end
         end else if (etime_mode || pwm_mode) begin
            if (cnt_r == {W{1'b0}}) begin
               cnt_nxt = load_r;
            end else begin
               cnt_nxt = cnt_r - 1'b1;
            end
            if (etime_mode && evt) begin
               set_nxt[`GTCP_IRQ_CE] = 1'b1;
            end
         end else if (cfg_r == `GTCP_CFG_16 || cfg_r == 3'h0) begin
            if (tick) begin
               if (cnt_r == {W{1'b0}}) begin
                  cnt_nxt = load_r;
                  set_nxt[`GTCP_IRQ_TO] = 1'b1;
                  en_clr_nxt = (mr == `GTCP_MR_ONESHOT);
               end else begin
                  cnt_nxt = cnt_r - 1'b1;
               end
            end
         end else if (cfg_r == 3'h1) begin
            if (evt) begin
               if (cnt_r == match_r) begin
                  cnt_nxt = {W{1'b0}};
                  set_nxt[`GTCP_IRQ_RTC] = 1'b1;
               end else begin
                  cnt_nxt = cnt_r + 1'b1;
               end
            end
         end
      end
   end

   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg_r <= 3'h0;
         mode_r <= 4'h0;
         ctl_r <= 7'h00;
         imr_r <= 4'h0;
         ris_r <= 4'h0;
         load_r <= `GTCP_LOAD_RST;
         match_r <= `GTCP_LOAD_RST;
         pr_r <= 8'h00;
         cnt_r <= `GTCP_LOAD_RST;
         cap_r <= `GTCP_LOAD_RST;
         pwm_r <= 1'b0;
      end else begin
         if (wr_i && addr_i == `GTCP_A_CFG) cfg_r <= wdata_i[2:0];
         if (wr_i && addr_i == `GTCP_A_MODE) mode_r <= wdata_i[3:0];
         if (wr_i && addr_i == `GTCP_A_IMR) imr_r <= wdata_i[3:0];
         if (wr_i && addr_i == `GTCP_A_PR) pr_r <= wdata_i[7:0];
         if (wr_i && addr_i == `GTCP_A_MATCH) match_r <= wdata_i[W-1:0];
         if (ctl_wr) begin
            ctl_r <= wdata_i[6:0];
         end else if (en_clr_nxt) begin
            ctl_r[`GTCP_CTL_EN] <= 1'b0;
         end
         // set wins over clear; no flags in pwm mode
         if (pwm_mode) begin
            ris_r <= ris_r & ~((wr_i && addr_i == `GTCP_A_ICR) ? wdata_i[3:0] : 4'h0);
         end else begin
            ris_r <= (ris_r & ~((wr_i && addr_i == `GTCP_A_ICR) ? wdata_i[3:0] : 4'h0))
                     | set_nxt;
         end
         if (wr_i && addr_i == `GTCP_A_ILR) begin
            load_r <= wdata_i[W-1:0];
            if (!en || !ecnt_mode) cnt_r <= wdata_i[W-1:0];
            else cnt_r <= cnt_nxt;
         end else if (ctl_wr && !en && wdata_i[`GTCP_CTL_EN] && cfg_r == 3'h1) begin
            cnt_r <= {{(W-1){1'b0}}, 1'b1};
         end else begin
            cnt_r <= cnt_nxt;
         end
         if (set_nxt[`GTCP_IRQ_CE]) cap_r <= cnt_r;
         // pwm output, registered for glitch-free edges
         if (!pwm_mode || !en) begin
            pwm_r <= 1'b0;
         end else if (cnt_r == load_r) begin
            pwm_r <= 1'b1;
         end else if (cnt_r == match_r) begin
            pwm_r <= 1'b0;
         end
      end
   end

   // outputs and read port
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ccp_o <= 1'b0;
         ccp_oe_o <= 1'b0;
         rdata_o <= 32'h0000_0000;
      end else begin
         ccp_oe_o <= pwm_mode;
         ccp_o <= pwm_r ^ ctl_r[`GTCP_CTL_PWML];
         rdata_o <= 32'h0000_0000;
         if (rd_i) begin
            case (addr_i)
               `GTCP_A_CFG: rdata_o <= {29'h0, cfg_r};
               `GTCP_A_MODE: rdata_o <= {28'h0, mode_r};
               `GTCP_A_CTL: rdata_o <= {25'h0, ctl_r};
               `GTCP_A_IMR: rdata_o <= {28'h0, imr_r};
               `GTCP_A_RIS: rdata_o <= {28'h0, ris_r};
               `GTCP_A_MIS: rdata_o <= {28'h0, ris_r & imr_r};
               `GTCP_A_ILR: rdata_o <= {{(32-W){1'b0}}, load_r};
               `GTCP_A_MATCH: rdata_o <= {{(32-W){1'b0}}, match_r};
               `GTCP_A_PR: rdata_o <= {24'h0, pr_r};
               `GTCP_A_CNT: rdata_o <= {{(32-W){1'b0}}, cnt_r};
               `GTCP_A_CAP: rdata_o <= {{(32-W){1'b0}}, cap_r};
               default: rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // gtcp_timer

/* File: gtcp_timer_properties.sv */
`timescale 1ns/1ns
module gtcp_timer_chk (
   // clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // register port
   input wire [3:0] addr_i,
   input wire [31:0] wdata_i,
   input wire wr_i,
   input wire rd_i,
   input wire [31:0] rdata_o,
   // pin
   input wire ccp_i,
   input wire ccp_o,
   input wire ccp_oe_o
);
   reg [3:0] mode_r;
   reg en_r;
   reg [15:0] load_r;
   wire pwm_w = mode_r == 4'ha;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         mode_r <= 4'h0;
         en_r <= 1'b0;
         load_r <= 16'hffff;
      end else if (wr_i) begin
         if (addr_i == 4'h1) mode_r <= wdata_i[3:0];
         if (addr_i == 4'h2) en_r <= wdata_i[0];
         if (addr_i == 4'h7) load_r <= wdata_i[15:0];
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   a_rise_quiet: assert property ($rose(rst_n_i) |-> !ccp_o && !ccp_oe_o)
      else $error("pin busy after reset");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
      else $error("read data without read");
   a_upper_zero: assert property (rdata_o[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_load_back: assert property ($past(rd_i) && $past(addr_i) == 4'h7
      |-> rdata_o[15:0] == $past(load_r)) else $error("load readback wrong");
   a_unmapped_zero: assert property ($past(rd_i) && $past(addr_i) > 4'hb
      |-> rdata_o == 32'h0000_0000) else $error("unmapped read not zero");
   a_oe_pwm_on: assert property (pwm_w && $past(pwm_w) |-> ccp_oe_o)
      else $error("pin not driven in pwm");
   a_oe_pwm_off: assert property (!pwm_w && !$past(pwm_w) |-> !ccp_oe_o)
      else $error("pin driven outside pwm");
   a_flag_clear: assert property (wr_i && addr_i == 4'h6 && !en_r
      ##1 rd_i && addr_i == 4'h4 |=> (rdata_o & $past(wdata_i, 2) & 32'h0000_000f) == 32'h0000_0000)
      else $error("flag survived clear");
endmodule // gtcp_timer_chk
bind gtcp_timer gtcp_timer_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ccp_i(ccp_i),
   .ccp_o(ccp_o), .ccp_oe_o(ccp_oe_o));

/* File: gtcp_edge_src.sv */
`timescale 1ns/1ns
module gtcp_edge_src #(
   parameter HOLD = 3
) (
   // control
   input wire clk_i,
   input wire start_i,
   input wire [7:0] num_i,
   // pin
   output reg pin_o,
   output wire busy_o
);
   reg [7:0] left_r = 8'h00;
   reg [3:0] cnt_r = 4'h0;
   initial pin_o = 1'b0;
   assign busy_o = left_r != 8'h00;
   always @(posedge clk_i) begin
      if (start_i) begin
         left_r <= num_i;
         cnt_r <= 4'h0;
      end else if (busy_o && cnt_r == HOLD - 1) begin
         pin_o <= ~pin_o;
         left_r <= left_r - 8'h01;
         cnt_r <= 4'h0;
      end else if (busy_o) begin
         cnt_r <= cnt_r + 4'h1;
      end
   end
endmodule // gtcp_edge_src

/* File: general_timer_capture_pwm_test.sv */
`timescale 1ns/1ns
module general_timer_capture_pwm_test;
   reg clk_i = 1'b0;
   reg rst_n_i = 1'b0;
   reg [3:0] addr_i = 4'h0;
   reg [31:0] wdata_i = 32'h0000_0000;
   reg wr_i = 1'b0;
   reg rd_i = 1'b0;
   reg go_r = 1'b0;
   reg [7:0] num_r = 8'h00;
   reg [31:0] v;
   wire [31:0] rdata_o;
   wire pin_w;
   wire ccp_o;
   wire ccp_oe_o;
   wire busy_w;
   integer fail_count = 0;
   integer check_count = 0;
   integer i;
   integer k;
   integer hi;
   integer oe_n;
   always #4 clk_i = ~clk_i;
   gtcp_timer DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ccp_i(pin_w), .ccp_o(ccp_o),
      .ccp_oe_o(ccp_oe_o));
   gtcp_edge_src SRC (.clk_i(clk_i), .start_i(go_r), .num_i(num_r), .pin_o(pin_w),
      .busy_o(busy_w));
   task conclude;
      begin
         $display("checks %0d mismatches %0d", check_count, fail_count);
         if (fail_count == 0 && check_count > 0) $display("Simulation passed");
         else $display("Simulation failed");
         $finish;
      end
   endtask
   task chk(input [31:0] got, input [15:0] lo, input [15:0] hv);
      begin
         check_count = check_count + 1;
         if (^got === 1'bx || got < {16'h0000, lo} || got > {16'h0000, hv}) begin
            fail_count = fail_count + 1;
            $display("MISMATCH %0t got %h", $time, got);
         end
      end
   endtask
   task wr(input [3:0] a, input [15:0] d);
      begin
         addr_i <= a;
         wdata_i <= {16'h0000, d};
         rd_i <= 1'b0;
         wr_i <= 1'b1;
         @(posedge clk_i);
      end
   endtask
   task rd(input [3:0] a, input [15:0] lo, input [15:0] hv);
      begin
         addr_i <= a;
         wr_i <= 1'b0;
         rd_i <= 1'b1;
         @(posedge clk_i);
         rd_i <= 1'b0;
         @(negedge clk_i);
         chk(rdata_o, lo, hv);
         @(posedge clk_i);
      end
   endtask
   // idle, optional edge burst, then count pin high cycles
   task run(input [7:0] n, input integer cyc);
      begin
         wr_i <= 1'b0;
         rd_i <= 1'b0;
         go_r <= n != 8'h00;
         num_r <= n;
         hi = 0;
         oe_n = 0;
         @(posedge clk_i);
         go_r <= 1'b0;
         for (k = 0; (busy_w || k == 0) && k < 500; k = k + 1) @(negedge clk_i);
         if (k == 500) begin
            fail_count = fail_count + 1;
            conclude;
         end
         repeat (cyc) begin
            @(negedge clk_i);
            hi = hi + ccp_o;
            oe_n = oe_n + ccp_oe_o;
         end
         @(posedge clk_i);
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count = fail_count + 1;
      conclude;
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      for (i = 0; i < 16; i = i + 1) begin
         v = (i == 7 || i == 8 || i == 10 || i == 11) ? 32'h0000_ffff : 32'h0000_0000;
         if (i != 6) rd(i[3:0], v[15:0], v[15:0]);
      end
      // edge count, both edges, four of six counted
      wr(4'h0, 16'h0004);
      wr(4'h1, 16'h0003);
      wr(4'h9, 16'h0005);
      wr(4'h7, 16'h000a);
      wr(4'h8, 16'h0006);
      wr(4'h3, 16'h0002);
      wr(4'h2, 16'h000d);
      run(8'h06, 10);
      chk(oe_n, 16'h0000, 16'h0000);
      rd(4'h4, 16'h0002, 16'h0002);
      rd(4'h5, 16'h0002, 16'h0002);
      rd(4'h2, 16'h000c, 16'h000c);
      rd(4'ha, 16'h000a, 16'h000a);
      wr(4'h2, 16'h000c);
      wr(4'h6, 16'h0002);
      rd(4'h4, 16'h0000, 16'h0000);
      // edge time, rising only
      wr(4'h1, 16'h0007);
      wr(4'h7, 16'h0040);
      wr(4'h3, 16'h0004);
      wr(4'h2, 16'h0001);
      run(8'h02, 4);
      rd(4'h4, 16'h0004, 16'h0004);
      rd(4'h5, 16'h0004, 16'h0004);
      rd(4'hb, 16'h0039, 16'h0039);
      run(8'h00, 150);
      rd(4'hb, 16'h0039, 16'h0039);
      rd(4'ha, 16'h0000, 16'h0040);
      // pwm, period 33, high 16
      wr(4'h2, 16'h0000);
      wr(4'h1, 16'h000a);
      wr(4'h7, 16'h0020);
      wr(4'h8, 16'h0010);
      wr(4'h6, 16'h000f);
      rd(4'h4, 16'h0000, 16'h0000);
      wr(4'h2, 16'h0001);
      run(8'h00, 20);
      run(8'h00, 66);
      chk(hi, 16'h0020, 16'h0020);
      chk(oe_n, 16'h0042, 16'h0042);
      rd(4'h4, 16'h0000, 16'h0000);
      wr(4'h2, 16'h0040);
      wr(4'h2, 16'h0041);
      run(8'h00, 20);
      run(8'h00, 66);
      chk(hi, 16'h0022, 16'h0022);
      chk(oe_n, 16'h0042, 16'h0042);
      rd(4'ha, 16'h0000, 16'h0020);
      // 16-bit one-shot, prescale 1, load 3
      wr(4'h2, 16'h0000);
      wr(4'h0, 16'h0004);
      wr(4'h1, 16'h0001);
      wr(4'h9, 16'h0001);
      wr(4'h7, 16'h0003);
      wr(4'h3, 16'h0001);
      wr(4'h2, 16'h0001);
      run(8'h00, 12);
      rd(4'h4, 16'h0001, 16'h0001);
      rd(4'h5, 16'h0001, 16'h0001);
      rd(4'h2, 16'h0000, 16'h0000);
      rd(4'ha, 16'h0003, 16'h0003);
      wr(4'h2, 16'h0000);
      wr(4'h6, 16'h0001);
      rd(4'h4, 16'h0000, 16'h0000);
      // 16-bit periodic with config 0, load 2
      wr(4'h0, 16'h0000);
      wr(4'h1, 16'h0002);
      wr(4'h7, 16'h0002);
      wr(4'h2, 16'h0001);
      run(8'h00, 20);
      rd(4'h2, 16'h0001, 16'h0001);
      rd(4'h4, 16'h0001, 16'h0001);
      wr(4'h2, 16'h0000);
      wr(4'h6, 16'h0001);
      rd(4'h4, 16'h0000, 16'h0000);
      // rtc, match 3, three rising edges
      wr(4'h0, 16'h0001);
      wr(4'h8, 16'h0003);
      wr(4'h3, 16'h0008);
      wr(4'h2, 16'h0011);
      run(8'h06, 10);
      rd(4'h4, 16'h0008, 16'h0008);
      rd(4'h5, 16'h0008, 16'h0008);
      rd(4'ha, 16'h0000, 16'h0000);
      wr(4'h2, 16'h0010);
      wr(4'h6, 16'h0008);
      rd(4'h4, 16'h0000, 16'h0000);
      conclude;
   end
endmodule // general_timer_capture_pwm_test
